// *** pos_line_port.v ***
// Overview of operation
// - Frame check is 32 bits unless the short check input selects 16 bits.
// - Transmitter appends frame check computed over all packet bytes.
// - Receiver recomputes frame check and flags any mismatch as error.
// - Framing select chooses SONET or SDH pointer coding on build and parse.
// - Programmable 8-bit section trace byte is inserted into section overhead.
// - Nine section, eighteen line, nine path overhead bytes, each its own slot.
// - Loopback follows the loop_mode input alone, with no reset default; the none selection removes any loop.
// - Line loop sends received line bytes straight back out.
// - Serial loop feeds own transmit line bytes into own receive path.
// - Parallel loop hands transmit packet bytes straight to receive output.
// - Path trace message up to 64 bytes is sent in path overhead, one byte each frame.
// - Payload scrambling on both directions when enabled, clear otherwise.
// - Protection moves receive traffic to protecting port on working degrade or failure; transmit stays on the working line.
// - Exactly one working port pairs with exactly one protecting port.
// - Only one valid packet-over-SONET port is accepted as backup.
// - Clearing the protection setting disables automatic switching.
// - Degrade threshold 10^-n, n 5 to 9, default 6, raises degrade alarm.
// - Failure threshold 10^-n, n 3 to 5, default 3, raises failure alarm.
// - Revertive returns after fault clears and restore timer expires; else never.
// - Lockout on protecting port suppresses automatic switching to it.
`include "pos_line_port_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module pos_line_port #(
    parameter PAYLOAD_LEN     = 234,
    parameter TICK_CYCLES     = `RESTORE_TICK_CYC,
    parameter WIN_FRAMES      = `MON_WIN_FRAMES
) (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst,
    // configuration
    input  wire        fcs_short,
    input  wire        framing_sdh,
    input  wire [7:0]  section_trace_byte,
    input  wire [1:0]  loop_mode,
    input  wire        scramble_en,
    input  wire [3:0]  degrade_error_threshold,
    input  wire [3:0]  failure_error_threshold,
    // path trace message store
    input  wire        trace_wr,
    input  wire [5:0]  trace_addr,
    input  wire [7:0]  trace_data,
    input  wire [6:0]  trace_len,
    // protection setup
    input  wire        prot_enable,
    input  wire [3:0]  backup_port_designation,
    input  wire        backup_valid,
    input  wire        backup_is_pos,
    input  wire        lockout,
    input  wire        revertive,
    input  wire [7:0]  restore_delay_timer,
    // packet transmit side
    input  wire [7:0]  tx_data,
    input  wire        tx_valid,
    input  wire        tx_eop,
    output reg         tx_ready_ff,
    output reg         tx_underrun_ff,
    // packet receive side
    output reg  [7:0]  rx_data_ff,
    output reg         rx_valid_ff,
    output reg         rx_end_ff,
    output reg         rx_err_ff,
    // lines
    input  wire [7:0]  line_rx_data,
    input  wire        line_rx_fp,
    input  wire [7:0]  prot_rx_data,
    input  wire        prot_rx_fp,
    output reg  [7:0]  line_tx_data_ff,
    output reg         line_tx_fp_ff,
    // status
    output reg  [7:0]  rx_section_trace_ff,
    output reg         framing_mismatch_ff,
    output reg         degrade_alarm_ff,
    output reg         failure_alarm_ff,
    output reg         on_protect_ff,
    output reg  [3:0]  active_backup_ff
);

    localparam        FRAME_LEN = `OH_BYTES + PAYLOAD_LEN;
    localparam [47:0] WIN_BITS  = WIN_FRAMES * FRAME_LEN * 8;
    localparam [2:0]  H_IDLE = 3'b001, H_DATA = 3'b010, H_FCS = 3'b100;
    localparam [2:0]  A_WORK = 3'b001, A_PROT = 3'b010, A_WAIT = 3'b100;

    // reflected crc over one byte, width chosen by the polynomial
    function [31:0] crc_byte;
        input [31:0] c;
        input [7:0]  d;
        input        short;
        integer      i;
        reg          fb;
        begin
            crc_byte = c;
            for (i = 0; i < 8; i = i + 1)
            begin
                fb = crc_byte[0] ^ d[i];
                crc_byte = crc_byte >> 1;
                if (fb)
                    crc_byte = crc_byte ^ (short ? `CRC16_POLY : `CRC32_POLY);
            end
        end
    endfunction

    // x^43+1 self-synchronous scrambler step, msb first
    function [50:0] scr_step;
        input [42:0] h;
        input [7:0]  d;
        input        descr;
        integer      i;
        reg   [42:0] s;
        reg   [7:0]  o;
        begin
            s = h;
            for (i = 7; i >= 0; i = i - 1)
            begin
                o[i] = d[i] ^ s[42];
                s = {s[41:0], descr ? d[i] : o[i]};
            end
            scr_step = {s, o};
        end
    endfunction

    function [29:0] pow10;
        input [3:0] n;
        begin
            case (n)
                4'h3:    pow10 = 30'd1000;
                4'h4:    pow10 = 30'd10000;
                4'h5:    pow10 = 30'd100000;
                4'h6:    pow10 = 30'd1000000;
                4'h7:    pow10 = 30'd10000000;
                4'h8:    pow10 = 30'd100000000;
                default: pow10 = 30'd1000000000;
            endcase
        end
    endfunction

    // ---------------- transmit ----------------
    reg  [7:0]  trace_mem [0:63];
    reg  [8:0]  tx_pos_ff;
    reg  [5:0]  trace_idx_ff;
    reg  [2:0]  hst_ff;
    reg  [1:0]  fcs_idx_ff;
    reg         esc_ff;
    reg  [7:0]  esc_byte_ff;
    reg         last_flag_ff;
    reg  [31:0] tcrc_ff;
    reg  [42:0] tscr_ff;
    reg  [7:0]  tbip_ff;
    reg  [7:0]  tbip_acc_ff;
    reg  [8:0]  nxt_tx_pos;
    reg  [2:0]  nxt_hst;
    reg  [1:0]  nxt_fcs_idx;
    reg         nxt_esc;
    reg  [7:0]  nxt_esc_byte;
    reg         nxt_last_flag;
    reg  [31:0] nxt_tcrc;
    reg  [42:0] nxt_tscr;
    reg  [7:0]  tx_byte;
    reg  [7:0]  raw;
    reg         underrun;
    reg  [50:0] tsr;
    wire        tx_acc    = tx_valid & tx_ready_ff;
    wire [1:0]  fcs_last  = fcs_short ? 2'd1 : 2'd3;
    wire [31:0] tcrc_inv  = ~tcrc_ff;

    // path trace message store
    always @(posedge ref_clk)
    begin
        if (trace_wr)
            trace_mem[trace_addr] <= trace_data;
    end

    // frame builder: overhead slots then hdlc payload with stuffing
    always @*
    begin
        nxt_tx_pos    = (tx_pos_ff == FRAME_LEN - 1) ? 9'h000 : tx_pos_ff + 9'h001;
        nxt_hst       = hst_ff;
        nxt_fcs_idx   = fcs_idx_ff;
        nxt_esc       = esc_ff;
        nxt_esc_byte  = esc_byte_ff;
        nxt_last_flag = last_flag_ff;
        nxt_tcrc      = tcrc_ff;
        nxt_tscr      = tscr_ff;
        raw           = `FLAG_BYTE;
        underrun      = 1'b0;
        tsr           = 51'h0;
        tx_byte       = 8'h00;
        if (tx_pos_ff < `OH_BYTES)
        begin
            case (tx_pos_ff)
                `OH_FRAME_A:    tx_byte = `FRAME_A_VAL;
                `OH_FRAME_B:    tx_byte = `FRAME_B_VAL;
                `OH_BIP:        tx_byte = tbip_ff;
                `OH_SECT_TRACE: tx_byte = section_trace_byte;
                `OH_POINTER:    tx_byte = framing_sdh ? `PTR_SDH_VAL : `PTR_SONET_VAL;
                `OH_PATH_TRACE: tx_byte = trace_mem[trace_idx_ff];
                `OH_SIG_LABEL:  tx_byte = scramble_en ? `LABEL_SCR_VAL : `LABEL_CLR_VAL;
                default:        tx_byte = 8'h00;
            endcase
        end
        else
        begin
            if (esc_ff)
            begin
                tx_byte = esc_byte_ff;
                nxt_esc = 1'b0;
            end
            else
            begin
                case (hst_ff)
                    H_IDLE:
                    begin
                        if (tx_acc)
                        begin
                            raw      = tx_data;
                            nxt_tcrc = crc_byte(fcs_short ? `CRC16_INIT : `CRC32_INIT, tx_data, fcs_short);
                            nxt_hst  = tx_eop ? H_FCS : H_DATA;
                        end
                    end
                    H_DATA:
                    begin
                        if (tx_acc)
                        begin
                            raw      = tx_data;
                            nxt_tcrc = crc_byte(tcrc_ff, tx_data, fcs_short);
                            nxt_hst  = tx_eop ? H_FCS : H_DATA;
                        end
                        else
                        begin
                            underrun = 1'b1; // abort: a flag ends the frame with a bad check
                            nxt_hst  = H_IDLE;
                        end
                    end
                    H_FCS:
                    begin
                        raw         = tcrc_inv[{fcs_idx_ff, 3'b000} +: 8];
                        nxt_fcs_idx = fcs_idx_ff + 2'd1;
                        if (fcs_idx_ff == fcs_last)
                        begin
                            nxt_fcs_idx = 2'd0;
                            nxt_hst     = H_IDLE;
                        end
                    end
                    default:
                        nxt_hst = H_IDLE;
                endcase
                nxt_last_flag = (raw == `FLAG_BYTE) && !(tx_acc || hst_ff == H_FCS);
                if ((tx_acc || hst_ff == H_FCS) && (raw == `FLAG_BYTE || raw == `ESC_BYTE))
                begin
                    tx_byte      = `ESC_BYTE;
                    nxt_esc      = 1'b1;
                    nxt_esc_byte = raw ^ `ESC_XOR;
                end
                else
                    tx_byte = raw;
            end
            tsr = scr_step(tscr_ff, tx_byte, 1'b0);
            if (scramble_en)
            begin
                tx_byte  = tsr[7:0];
                nxt_tscr = tsr[50:8];
            end
        end
    end

    // transmit registers and line output
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            tx_pos_ff      <= 9'h000;
            trace_idx_ff   <= 6'h00;
            hst_ff         <= H_IDLE;
            fcs_idx_ff     <= 2'd0;
            esc_ff         <= 1'b0;
            esc_byte_ff    <= 8'h00;
            last_flag_ff   <= 1'b0;
            tcrc_ff        <= `CRC32_INIT;
            tscr_ff        <= 43'h0;
            tbip_ff        <= 8'h00;
            tbip_acc_ff    <= 8'h00;
            tx_ready_ff    <= 1'b0;
            tx_underrun_ff <= 1'b0;
            line_tx_data_ff <= 8'h00;
            line_tx_fp_ff  <= 1'b0;
        end
        else
        begin
            tx_pos_ff      <= nxt_tx_pos;
            hst_ff         <= nxt_hst;
            fcs_idx_ff     <= nxt_fcs_idx;
            esc_ff         <= nxt_esc;
            esc_byte_ff    <= nxt_esc_byte;
            last_flag_ff   <= nxt_last_flag;
            tcrc_ff        <= nxt_tcrc;
            tscr_ff        <= nxt_tscr;
            tx_underrun_ff <= underrun;
            tx_ready_ff    <= (nxt_tx_pos >= `OH_BYTES) && !nxt_esc &&
                              (nxt_hst == H_DATA || (nxt_hst == H_IDLE && nxt_last_flag));
            if (tx_pos_ff == FRAME_LEN - 1)
            begin
                tbip_ff      <= tbip_acc_ff ^ tx_byte;
                tbip_acc_ff  <= 8'h00;
                trace_idx_ff <= ({1'b0, trace_idx_ff} + 7'd1 >= trace_len) ? 6'h00 : trace_idx_ff + 6'h01;
            end
            else
                tbip_acc_ff <= tbip_acc_ff ^ tx_byte;
            if (loop_mode == `LOOP_LINE)
            begin
                line_tx_data_ff <= line_rx_data;
                line_tx_fp_ff   <= line_rx_fp;
            end
            else
            begin
                line_tx_data_ff <= tx_byte;
                line_tx_fp_ff   <= (tx_pos_ff == 9'h000);
            end
        end
    end

    // ---------------- working port monitor ----------------
    wire        serial   = (loop_mode == `LOOP_SERIAL);
    wire [7:0]  w_data   = serial ? line_tx_data_ff : line_rx_data;
    wire        w_fp     = serial ? line_tx_fp_ff : line_rx_fp;
    wire [3:0]  sd_n     = (degrade_error_threshold < `SD_MIN || degrade_error_threshold > `SD_MAX) ?
                           `SD_DEF : degrade_error_threshold;
    wire [3:0]  sf_n     = (failure_error_threshold < `SF_MIN || failure_error_threshold > `SF_MAX) ?
                           `SF_DEF : failure_error_threshold;
    reg  [8:0]  wpos_ff;
    reg  [7:0]  wbip_ff;
    reg  [7:0]  wbip_acc_ff;
    reg  [17:0] errs_ff;
    reg  [13:0] win_ff;
    reg  [3:0]  nerr;
    integer     k;

    // errored bits in the parity byte
    always @*
    begin
        nerr = 4'h0;
        for (k = 0; k < 8; k = k + 1)
            nerr = nerr + {3'b000, w_data[k] ^ wbip_ff[k]};
    end

    // parity check per frame, error rate judged per observation window
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            wpos_ff          <= 9'h000;
            wbip_ff          <= 8'h00;
            wbip_acc_ff      <= 8'h00;
            errs_ff          <= 18'h0;
            win_ff           <= 14'h0;
            degrade_alarm_ff <= 1'b0;
            failure_alarm_ff <= 1'b0;
        end
        else
        begin
            wpos_ff <= w_fp ? 9'h001 : wpos_ff + 9'h001;
            if (w_fp)
            begin
                wbip_ff     <= wbip_acc_ff;
                wbip_acc_ff <= w_data;
            end
            else
                wbip_acc_ff <= wbip_acc_ff ^ w_data;
            if (wpos_ff == `OH_BIP && !w_fp)
                errs_ff <= errs_ff + {14'h0, nerr};
            if (w_fp)
            begin
                win_ff <= win_ff + 14'h1;
                if (win_ff == WIN_FRAMES - 1)
                begin
                    win_ff           <= 14'h0;
                    errs_ff          <= 18'h0;
                    degrade_alarm_ff <= ({errs_ff, 30'h0} >> 30) * pow10(sd_n) > WIN_BITS;
                    failure_alarm_ff <= ({errs_ff, 30'h0} >> 30) * pow10(sf_n) > WIN_BITS;
                end
            end
        end
    end

    // ---------------- protection switching ----------------
    wire        aps_ok  = prot_enable && backup_valid && backup_is_pos;
    wire        fault   = degrade_alarm_ff || failure_alarm_ff;
    reg  [2:0]  ast_ff;
    reg  [31:0] tick_ff;
    reg  [7:0]  wait_ff;
    wire        tick    = (tick_ff == TICK_CYCLES - 1);

    // working/protecting selection state
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            ast_ff           <= A_WORK;
            tick_ff          <= 32'h0;
            wait_ff          <= 8'h00;
            active_backup_ff <= 4'h0;
        end
        else
        begin
            tick_ff <= tick ? 32'h0 : tick_ff + 32'h1;
            if (aps_ok)
                active_backup_ff <= backup_port_designation;
            case (ast_ff)
                A_WORK:
                    if (aps_ok && fault && !lockout)
                        ast_ff <= A_PROT;
                A_PROT:
                    if (!aps_ok)
                        ast_ff <= A_WORK;
                    else if (revertive && !fault)
                    begin
                        ast_ff  <= A_WAIT;
                        wait_ff <= restore_delay_timer;
                        tick_ff <= 32'h0;
                    end
                A_WAIT:
                    if (!aps_ok)
                        ast_ff <= A_WORK;
                    else if (fault || !revertive)
                        ast_ff <= A_PROT;
                    else if (wait_ff == 8'h00)
                        ast_ff <= A_WORK;
                    else if (tick)
                        wait_ff <= wait_ff - 8'h01;
                default:
                    ast_ff <= A_WORK;
            endcase
        end
    end

    // ---------------- receive ----------------
    wire [7:0]  s_data  = on_protect_ff ? prot_rx_data : w_data;
    wire        s_fp    = on_protect_ff ? prot_rx_fp : w_fp;
    wire        want    = (ast_ff != A_WORK);
    wire        swap    = s_fp && (want != on_protect_ff);
    reg  [8:0]  rpos_ff;
    reg  [42:0] rscr_ff;
    reg         resc_ff;
    reg         in_pkt_ff;
    reg  [2:0]  held_ff;
    reg  [31:0] dly_ff;
    reg  [31:0] rcrc_ff;
    reg  [50:0] rsr;
    reg  [7:0]  pb;
    wire        pay     = !s_fp && rpos_ff >= `OH_BYTES;
    wire [2:0]  depth   = fcs_short ? 3'd2 : 3'd4;
    wire [31:0] good    = fcs_short ? `CRC16_GOOD : `CRC32_GOOD;

    // descramble and unstuff the selected stream
    always @*
    begin
        rsr = scr_step(rscr_ff, s_data, 1'b1);
        pb  = (scramble_en ? rsr[7:0] : s_data) ^ (resc_ff ? `ESC_XOR : 8'h00);
    end

    // receive processor: overhead parse, delimiting, check and delivery
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            rpos_ff             <= 9'h000;
            rscr_ff             <= 43'h0;
            resc_ff             <= 1'b0;
            in_pkt_ff           <= 1'b0;
            held_ff             <= 3'd0;
            dly_ff              <= 32'h0;
            rcrc_ff             <= `CRC32_INIT;
            on_protect_ff       <= 1'b0;
            rx_data_ff          <= 8'h00;
            rx_valid_ff         <= 1'b0;
            rx_end_ff           <= 1'b0;
            rx_err_ff           <= 1'b0;
            rx_section_trace_ff <= 8'h00;
            framing_mismatch_ff <= 1'b0;
        end
        else
        begin
            rx_valid_ff <= 1'b0;
            rx_end_ff   <= 1'b0;
            rx_err_ff   <= 1'b0;
            rpos_ff     <= s_fp ? 9'h001 : rpos_ff + 9'h001;
            if (loop_mode == `LOOP_PARALLEL)
            begin
                rx_valid_ff <= tx_acc;
                rx_data_ff  <= tx_data;
                rx_end_ff   <= tx_acc && tx_eop;
                in_pkt_ff   <= 1'b0;
            end
            else if (swap)
            begin
                on_protect_ff <= want;
                rx_end_ff     <= in_pkt_ff;
                rx_err_ff     <= in_pkt_ff;
                in_pkt_ff     <= 1'b0;
                resc_ff       <= 1'b0;
            end
            else if (!pay)
            begin
                if (rpos_ff == `OH_SECT_TRACE)
                    rx_section_trace_ff <= s_data;
                if (rpos_ff == `OH_POINTER)
                    framing_mismatch_ff <= s_data != (framing_sdh ? `PTR_SDH_VAL : `PTR_SONET_VAL);
            end
            else
            begin
                rscr_ff <= rsr[50:8];
                if (!resc_ff && pb == `FLAG_BYTE)
                begin
                    if (in_pkt_ff && held_ff == depth)
                    begin
                        rx_end_ff <= 1'b1;
                        rx_err_ff <= rcrc_ff != good;
                    end
                    in_pkt_ff <= 1'b0;
                end
                else if (!resc_ff && pb == `ESC_BYTE)
                    resc_ff <= 1'b1;
                else
                begin
                    resc_ff <= 1'b0;
                    if (!in_pkt_ff)
                    begin
                        in_pkt_ff <= 1'b1;
                        held_ff   <= 3'd1;
                        dly_ff    <= {24'h0, pb};
                        rcrc_ff   <= crc_byte(fcs_short ? `CRC16_INIT : `CRC32_INIT, pb, fcs_short);
                    end
                    else
                    begin
                        dly_ff  <= {dly_ff[23:0], pb};
                        rcrc_ff <= crc_byte(rcrc_ff, pb, fcs_short);
                        if (held_ff == depth)
                        begin
                            rx_valid_ff <= 1'b1;
                            rx_data_ff  <= fcs_short ? dly_ff[15:8] : dly_ff[31:24];
                        end
                        else
                            held_ff <= held_ff + 3'd1;
                    end
                end
            end
        end
    end

endmodule // pos_line_port

`default_nettype wire

// *** pos_line_port_regs.vh ***
`ifndef POS_LINE_PORT_REGS_VH
`define POS_LINE_PORT_REGS_VH

// overhead layout: byte index within the overhead block at the head of each frame
`define SOH_BYTES        9
`define LOH_BYTES        18
`define POH_BYTES        9
`define OH_BYTES         36
`define OH_FRAME_A       9'h000
`define OH_FRAME_B       9'h001
`define OH_BIP           9'h002
`define OH_SECT_TRACE    9'h008
`define OH_POINTER       9'h009
`define OH_PATH_TRACE    9'h01b
`define OH_SIG_LABEL     9'h01d

// overhead byte values
`define FRAME_A_VAL      8'hf6
`define FRAME_B_VAL      8'h28
`define PTR_SONET_VAL    8'h62
`define PTR_SDH_VAL      8'h6a
`define LABEL_SCR_VAL    8'h16
`define LABEL_CLR_VAL    8'hcf

// hdlc-like delimiting
`define FLAG_BYTE        8'h7e
`define ESC_BYTE         8'h7d
`define ESC_XOR          8'h20
`define CRC32_POLY       32'hedb88320
`define CRC16_POLY       32'h00008408
`define CRC32_INIT       32'hffffffff
`define CRC16_INIT       32'h0000ffff
`define CRC32_GOOD       32'hdebb20e3
`define CRC16_GOOD       32'h0000f0b8

// loopback selections
`define LOOP_NONE        2'h0
`define LOOP_LINE        2'h1
`define LOOP_SERIAL      2'h2
`define LOOP_PARALLEL    2'h3

// error rate thresholds, exponent n of 10^-n
`define SD_MIN           4'h5
`define SD_MAX           4'h9
`define SD_DEF           4'h6
`define SF_MIN           4'h3
`define SF_MAX           4'h5
`define SF_DEF           4'h3

// timing
`define CLK_PERIOD_NS    5
`define RESTORE_TICK_NS  1000000
`define RESTORE_TICK_CYC (`RESTORE_TICK_NS / `CLK_PERIOD_NS)
`define MON_WIN_FRAMES   8000

`endif

// *** pos_line_port_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module pos_line_port_monitor (
    // clock and settings
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       framing_sdh,
    input wire logic [7:0] section_trace_byte,
    input wire logic [1:0] loop_mode,
    input wire logic       prot_enable,
    input wire logic       lockout,
    input wire logic       scramble_en,
    // lines and status
    input wire logic       rx_end_ff,
    input wire logic       rx_err_ff,
    input wire logic [7:0] line_rx_data,
    input wire logic [7:0] line_tx_data_ff,
    input wire logic       line_tx_fp_ff,
    input wire logic       on_protect_ff
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // own frame start and its alignment bytes
    wire lp = loop_mode == 2'h1;
    sequence own_fp; line_tx_fp_ff && !lp; endsequence
    sequence head; line_tx_data_ff == 8'hf6 ##1 line_tx_data_ff == 8'h28; endsequence
    a_frame_head: assert property (own_fp |-> head) else $error("head");
    a_trace_slot: assert property (own_fp |-> ##8 (lp || line_tx_data_ff == section_trace_byte))
        else $error("trace");
    a_pointer_code: assert property (own_fp |-> ##9 (lp || line_tx_data_ff == (framing_sdh ? 8'h6a : 8'h62)))
        else $error("pointer");
    a_label_clear: assert property (own_fp |-> ##29 (lp || line_tx_data_ff == ($past(scramble_en) ? 8'h16 : 8'hcf)))
        else $error("label");
    a_line_echo: assert property (lp && $past(lp) && !$past(rst) |-> line_tx_data_ff == $past(line_rx_data))
        else $error("echo");
    a_err_at_end: assert property (rx_err_ff |-> rx_end_ff) else $error("err");
    a_prot_removed: assert property ($fell(prot_enable) |-> ##[1:400] !on_protect_ff) else $error("prot");
    a_lockout_holds: assert property (lockout && $past(lockout, 100) |-> !$rose(on_protect_ff))
        else $error("lockout");
endmodule // pos_line_port_monitor
bind pos_line_port pos_line_port_monitor mon (.*);
`default_nettype wire

// *** line_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module line_peer #(
    parameter int FRAME_LEN = 76
) (
    // clock, reset, parity spoiling
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       bad_parity,
    // line toward the port
    output var logic [7:0] rx_data,
    output var logic       rx_fp
);
    logic [8:0] pos_ff;
    // fixed frame whose bytes cancel, so parity only fails when spoiled
    always_ff @(posedge ref_clk)
    begin
        pos_ff <= (rst || pos_ff == 9'(FRAME_LEN - 1)) ? 9'h000 : pos_ff + 9'h001;
        rx_fp <= !rst && pos_ff == 9'h000;
        case (pos_ff)
            9'h000: rx_data <= 8'hf6;
            9'h001: rx_data <= 8'h28;
            9'h003: rx_data <= bad_parity ? 8'h8c : 8'h73;
            9'h009: rx_data <= 8'h62;
            9'h01d: rx_data <= 8'hcf;
            default: rx_data <= 8'h00;
        endcase
    end
endmodule // line_peer
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    // settings and stimulus
    logic       ref_clk = 0, rst = 1, fcs_short = 0, framing_sdh = 0, prot_enable = 0, lockout = 0, bad = 0;
    logic       backup_valid = 1, backup_is_pos = 1, revertive = 1, tx_valid = 0, tx_eop = 0, scramble_en = 0;
    logic [7:0] section_trace_byte = 8'ha5, restore_delay_timer = 8'h03, tx_data = 8'h00;
    logic [3:0] degrade_error_threshold = 4'h6, failure_error_threshold = 4'h3, backup_port_designation = 4'h9;
    logic [1:0] loop_mode = 2'h0;
    // observed outputs
    logic       tx_ready_ff, rx_valid_ff, rx_end_ff, rx_err_ff, framing_mismatch_ff, degrade_alarm_ff, line_tx_fp_ff;
    logic       failure_alarm_ff, on_protect_ff, line_rx_fp, prot_rx_fp, got_end, got_err, tx_underrun_ff;
    logic [7:0] rx_data_ff, rx_section_trace_ff, line_tx_data_ff, line_rx_data, prot_rx_data, got[$];
    logic [3:0] active_backup_ff;
    int         mismatches = 0, samples_checked = 0, k;
    pos_line_port #(.PAYLOAD_LEN(40), .TICK_CYCLES(4), .WIN_FRAMES(2)) dut (.*, .trace_wr(1'b0),
        .trace_addr(6'h00), .trace_data(8'h00), .trace_len(7'h01));
    line_peer wpeer (.ref_clk, .rst, .bad_parity(bad), .rx_data(line_rx_data), .rx_fp(line_rx_fp));
    line_peer ppeer (.ref_clk, .rst, .bad_parity(1'b0), .rx_data(prot_rx_data), .rx_fp(prot_rx_fp));
    // port clock
    initial forever #2.5 ref_clk = ~ref_clk;
    // gather received bytes and packet endings
    always @(posedge ref_clk)
    begin
        if (rx_valid_ff === 1'b1) got.push_back(rx_data_ff);
        if (rx_end_ff === 1'b1) {got_end, got_err} = {1'b1, rx_err_ff};
    end
    task chk(input logic [31:0] a, input logic [31:0] e);
        samples_checked++;
        if (a !== e) begin mismatches++; $display("unexpected at %0t: %h not %h", $time, a, e); end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wait_on(ref logic s, input logic v);
        for (k = 0; s !== v; k++)
        begin
            if (k == 3000) begin chk(s, v); stop_test; end
            @(posedge ref_clk);
        end
        @(negedge ref_clk);
    endtask
    task pkt(input int n);
        got.delete();
        got_end = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            tx_data = 8'h7c + 8'(i);
            tx_eop = i == n - 1;
            tx_valid = 1'b1;
            @(posedge ref_clk);
            wait_on(tx_ready_ff, 1'b1);
        end
        tx_valid = 1'b0;
        wait_on(got_end, 1'b1);
        chk(got.size(), n);
        chk(got_err, 1'b0);
        for (int i = 0; i < n; i++) chk(got[i], 8'h7c + 8'(i));
        $display("packet of %0d done", n);
    endtask
    initial
    begin
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        for (int m = 0; m < 3; m++)
        begin
            loop_mode = m == 0 ? 2'h3 : 2'h2;
            fcs_short = m == 2;
            scramble_en = m == 1;
            repeat (160) @(negedge ref_clk);
            pkt(m + 5);
        end
        chk(rx_section_trace_ff, section_trace_byte);
        loop_mode = 2'h1;
        framing_sdh = 1'b1;
        wait_on(framing_mismatch_ff, 1'b1);
        chk(framing_mismatch_ff, 1'b1);
        framing_sdh = 1'b0;
        wait_on(framing_mismatch_ff, 1'b0);
        loop_mode = 2'h0;
        $display("framing done");
        {prot_enable, lockout, bad} = 3'h7;
        wait_on(degrade_alarm_ff, 1'b1);
        repeat (400) @(negedge ref_clk);
        chk(on_protect_ff, 1'b0);
        lockout = 1'b0;
        wait_on(on_protect_ff, 1'b1);
        chk(active_backup_ff, backup_port_designation);
        chk(failure_alarm_ff, 1'b1);
        bad = 1'b0;
        wait_on(on_protect_ff, 1'b0);
        chk(degrade_alarm_ff, 1'b0);
        bad = 1'b1;
        wait_on(on_protect_ff, 1'b1);
        chk(on_protect_ff, 1'b1);
        prot_enable = 1'b0;
        wait_on(on_protect_ff, 1'b0);
        chk(on_protect_ff, 1'b0);
        $display("protection done");
        stop_test;
    end
endmodule // tb
`default_nettype wire
